// *** src/rxcf_fifo.sv ***
// Purpose: frame byte buffer toward the receive queue
// Assumes: depth a power of two
// Notes: source stalls on in_ready low only while draining; during the frame it marks overrun
`timescale 1ns/1ns
module rxcf_fifo #(
    parameter int W = 10,
    parameter int D = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    import rxcf_pkg::*;
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } rxcf_fifo_s;

    rxcf_fifo_s s;
    rxcf_fifo_s next_s;
    logic [W-1:0] mem [D];
    logic wr;
    logic rd;

    assign in_ready = s.cnt != (AW+1)'(D);
    assign out_valid = s.cnt != '0;
    assign out_data = mem[s.rp];
    assign wr = in_valid & in_ready;
    assign rd = out_valid & out_ready;

    always_comb
    begin
        next_s = s;
        if (wr)
        begin
            next_s.wp = s.wp + 1'b1;
        end
        if (rd)
        begin
            next_s.rp = s.rp + 1'b1;
        end
        if (wr & ~rd)
        begin
            next_s.cnt = s.cnt + 1'b1;
        end
        else if (rd & ~wr)
        begin
            next_s.cnt = s.cnt - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    always_ff @(posedge pclk)
    begin
        if (wr)
        begin
            mem[s.wp] <= in_data;
        end
    end

endmodule

// *** src/rxcf_pause_timer.sv ***
// Purpose: pause quanta countdown that holds the transmitter
// Assumes: one quantum is 512 bit times at 100 Mb/s
// Notes: clear wins over load
`timescale 1ns/1ns
module rxcf_pause_timer #(
    parameter int QUANTA_CYC = rxcf_pkg::RXCF_QUANTA_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [15:0] quanta,
    input wire logic clear,
    output logic hold
);
    import rxcf_pkg::*;
    localparam int CW = $clog2(QUANTA_CYC + 1);

    typedef struct packed {
        logic [15:0] left;
        logic [CW-1:0] pre;
        logic hold;
    } rxcf_pt_s;

    rxcf_pt_s s;
    rxcf_pt_s next_s;

    assign hold = s.hold;

    always_comb
    begin
        next_s = s;
        if (clear)
        begin
            next_s.left = '0;
            next_s.pre = '0;
        end
        else if (load)
        begin
            next_s.left = quanta;
            next_s.pre = '0;
        end
        else if (s.left != '0)
        begin
            // quantum tick from the prescaler
            if (s.pre == CW'(QUANTA_CYC - 1))
            begin
                next_s.pre = '0;
                next_s.left = s.left - 1'b1;
            end
            else
            begin
                next_s.pre = s.pre + 1'b1;
            end
        end
        next_s.hold = next_s.left != '0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

endmodule

// *** src/rxcf_pkg.sv ***
// Purpose: shared constants and helpers of the receive control filter
// Assumes: byte stream from the port, octet 0 of the address sent first
// Notes: field positions index the receive control word
package rxcf_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] RXCF_CTRL_OFS = 8'h04;
    localparam logic [7:0] RXCF_STATUS_OFS = 8'h10;
    localparam logic [15:0] RXCF_CTRL_RST = 16'h0000;
    localparam logic [15:0] RXCF_CTRL_MASK = 16'h06fd;
    localparam int RXCF_B_EN = 0;
    localparam int RXCF_B_HASH = 2;
    localparam int RXCF_B_STRIP = 3;
    localparam int RXCF_B_PROM = 4;
    localparam int RXCF_B_UC = 5;
    localparam int RXCF_B_MC = 6;
    localparam int RXCF_B_BC = 7;
    localparam int RXCF_B_KEEP = 9;
    localparam int RXCF_B_PAUSE = 10;

    // ----------------------------------------
    // frame layout
    // ----------------------------------------
    localparam logic [2:0] RXCF_HOLD = 3'h6;
    localparam logic [2:0] RXCF_LAST_STRIP = 3'h1;
    localparam logic [2:0] RXCF_LAST_KEEP = 3'h5;
    localparam logic [10:0] RXCF_DA_END = 11'h006;
    localparam logic [10:0] RXCF_MIN_LEN = 11'h00a;
    localparam logic [10:0] RXCF_POS_TYPE = 11'h00c;
    localparam logic [10:0] RXCF_POS_TIME = 11'h010;
    localparam logic [10:0] RXCF_PAUSE_LEN = 11'h012;
    localparam logic [10:0] RXCF_IDX_MAX = 11'h7ff;
    localparam logic [47:0] RXCF_PAUSE_DA = 48'h0180c2000001;
    localparam logic [31:0] RXCF_PAUSE_TYPE_OPC = 32'h88080001;
    localparam logic [31:0] RXCF_CRC_INIT = 32'hffffffff;
    localparam logic [31:0] RXCF_CRC_POLY = 32'hedb88320;

    // ----------------------------------------
    // timing and buffering
    // ----------------------------------------
    localparam int RXCF_CLK_MHZ = 250;
    localparam int RXCF_BIT_NS = 10;
    localparam int RXCF_QUANTA_BITS = 512;
    localparam int RXCF_QUANTA_CYC =
        (RXCF_QUANTA_BITS * RXCF_BIT_NS * RXCF_CLK_MHZ + 999) / 1000;
    localparam int RXCF_FIFO_W = 10;
    localparam int RXCF_FIFO_D = 32;

    typedef enum logic [1:0] {RXCF_IDLE, RXCF_FRAME, RXCF_DRAIN} rxcf_st_e;

    function automatic logic [7:0] rxcf_octet(input logic [47:0] a,
                                              input logic [2:0] i);
        logic [47:0] t;
        t = a << (8 * i);
        return t[47:40];
    endfunction

    function automatic logic [31:0] rxcf_crc_byte(input logic [31:0] c,
                                                  input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int k = 0; k < 8; k++)
        begin
            r = r[0] ? ((r >> 1) ^ RXCF_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

endpackage

// *** src/rxcf_top.sv ***
// Purpose: receive control and address filter of a 10/100 MAC
// Assumes: one byte per rx_valid, bytes at least 8 cycles apart
// Notes: rejected frames never reach the queue; overrun, short and crc-failing ones end discarded, crc-failing ones kept when keep is set
//
// What this block does
// - honour pause frames only if enabled, full duplex
// - keep or discard frames failing crc
// - broadcast accept passes every broadcast frame
// - group accept passes multicast, broadcast included
// - station match passes unicast equal to address
// - promiscuous accept passes every frame
// - strip or keep the four crc bytes
// - hash enable passes multicast hitting table
// - enable starts; disable stops after current frame
//
// Local design decision: the APB slave port.
`timescale 1ns/1ns
module rxcf_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    input wire logic rx_crc_err,
    input wire logic full_duplex,
    input wire logic [47:0] station_addr,
    input wire logic [63:0] hash_table,
    output logic q_valid,
    output logic [7:0] q_data,
    output logic q_last,
    output logic q_discard,
    input wire logic q_ready,
    output logic tx_hold
);
    import rxcf_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] ctrl;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        rxcf_st_e st;
        logic [10:0] idx;
        logic [47:0] dly;
        logic [2:0] fill;
        logic [2:0] cnt;
        logic [31:0] crc;
        logic bc;
        logic mc;
        logic match;
        logic pda;
        logic ptype;
        logic [15:0] ptime;
        logic crc_err;
        logic overrun;
        logic pause_load;
    } rxcf_state_s;

    rxcf_state_s s;
    rxcf_state_s next_s;
    logic push_v;
    logic push_last;
    logic push_disc;
    logic fifo_ready;
    logic fifo_v;
    logic [RXCF_FIFO_W-1:0] fifo_d;
    logic accept;
    logic disc;
    logic start;
    logic take;
    logic [2:0] p;
    logic [2:0] tp;
    logic apb_acc;

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign apb_acc = psel & penable;

    // address decision from the destination flags
    assign accept = s.ctrl[RXCF_B_PROM]
        | (s.bc & s.ctrl[RXCF_B_BC])
        | (s.mc & s.ctrl[RXCF_B_MC])
        | (s.mc & s.ctrl[RXCF_B_HASH] & hash_table[s.crc[5:0]])
        | (~s.mc & s.match & s.ctrl[RXCF_B_UC]);
    assign disc = (s.crc_err & ~s.ctrl[RXCF_B_KEEP]) | s.overrun
        | (s.idx < RXCF_MIN_LEN);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        next_s = s;
        push_v = 1'b0;
        push_last = 1'b0;
        push_disc = 1'b0;
        p = 3'h0;
        tp = 3'h0;
        next_s.pause_load = 1'b0;
        next_s.pready = apb_acc & ~s.pready;
        next_s.pslverr = 1'b0;
        next_s.prdata = '0;
        if (apb_acc & ~s.pready)
        begin
            unique case (paddr)
                RXCF_CTRL_OFS: next_s.prdata = {16'h0000, s.ctrl};
                RXCF_STATUS_OFS:
                    next_s.prdata = {30'h0, tx_hold, s.st != RXCF_IDLE};
                default: next_s.pslverr = 1'b1;
            endcase
        end
        if (apb_acc & s.pready & pwrite & (paddr == RXCF_CTRL_OFS))
        begin
            next_s.ctrl = pwdata[15:0] & RXCF_CTRL_MASK;
        end

        // start only at a frame boundary
        start = (s.st == RXCF_IDLE) & rx_valid & s.ctrl[RXCF_B_EN];
        take = rx_valid & (start | (s.st == RXCF_FRAME));
        if (start)
        begin
            next_s.st = RXCF_FRAME;
            next_s.idx = '0;
            next_s.fill = '0;
            next_s.crc = RXCF_CRC_INIT;
            next_s.bc = 1'b1;
            next_s.match = 1'b1;
            next_s.pda = 1'b1;
            next_s.ptype = 1'b1;
            next_s.overrun = 1'b0;
            next_s.crc_err = 1'b0;
        end
        if (take)
        begin
            if ((s.st == RXCF_FRAME) & (s.fill == RXCF_HOLD) & accept)
            begin
                push_v = 1'b1;
                if (!fifo_ready)
                begin
                    next_s.overrun = 1'b1;
                end
            end
            p = next_s.idx[2:0];
            tp = next_s.idx[2:0] - RXCF_POS_TYPE[2:0];
            if (next_s.idx < RXCF_DA_END)
            begin
                next_s.bc = next_s.bc & (rx_data == 8'hff);
                next_s.match = next_s.match
                    & (rx_data == rxcf_octet(station_addr, p));
                next_s.pda = next_s.pda
                    & (rx_data == rxcf_octet(RXCF_PAUSE_DA, p));
                next_s.crc = rxcf_crc_byte(next_s.crc, rx_data);
                if (next_s.idx == '0)
                begin
                    next_s.mc = rx_data[0];
                end
            end
            if ((next_s.idx >= RXCF_POS_TYPE) & (next_s.idx < RXCF_POS_TIME))
            begin
                next_s.ptype = next_s.ptype & (rx_data
                    == rxcf_octet({RXCF_PAUSE_TYPE_OPC, 16'h0000}, tp));
            end
            if (next_s.idx == RXCF_POS_TIME)
            begin
                next_s.ptime[15:8] = rx_data;
            end
            if (next_s.idx == RXCF_POS_TIME + 11'h001)
            begin
                next_s.ptime[7:0] = rx_data;
            end
            next_s.dly = {next_s.dly[39:0], rx_data};
            if (next_s.fill != RXCF_HOLD)
            begin
                next_s.fill = next_s.fill + 3'h1;
            end
            if (next_s.idx != RXCF_IDX_MAX)
            begin
                next_s.idx = next_s.idx + 11'h001;
            end
            if (rx_last)
            begin
                next_s.st = RXCF_DRAIN;
                next_s.cnt = '0;
                next_s.crc_err = rx_crc_err;
                // valid pause frame loads the timer
                next_s.pause_load = next_s.pda & next_s.ptype & ~rx_crc_err
                    & (next_s.idx >= RXCF_PAUSE_LEN)
                    & s.ctrl[RXCF_B_PAUSE] & full_duplex;
            end
        end
        if (s.st == RXCF_DRAIN)
        begin
            if (!(accept & (s.fill == RXCF_HOLD)))
            begin
                next_s.st = RXCF_IDLE;
            end
            else
            begin
                push_v = 1'b1;
                push_last = s.ctrl[RXCF_B_STRIP] ? (s.cnt == RXCF_LAST_STRIP)
                    : (s.cnt == RXCF_LAST_KEEP);
                push_disc = push_last & disc;
                if (fifo_ready)
                begin
                    next_s.dly = {s.dly[39:0], 8'h00};
                    next_s.cnt = s.cnt + 3'h1;
                    if (push_last)
                    begin
                        next_s.st = RXCF_IDLE;
                    end
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
            s.ctrl <= RXCF_CTRL_RST;
            s.st <= RXCF_IDLE;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // buffer and pause timer
    // ----------------------------------------
    rxcf_fifo #(
        .W(RXCF_FIFO_W),
        .D(RXCF_FIFO_D)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(push_v),
        .in_data({push_disc, push_last, s.dly[47:40]}),
        .in_ready(fifo_ready),
        .out_valid(fifo_v),
        .out_data(fifo_d),
        .out_ready(q_ready)
    );

    assign q_valid = fifo_v;
    assign q_data = fifo_d[7:0];
    assign q_last = fifo_d[8];
    assign q_discard = fifo_d[9];

    // ignored when disabled or half duplex
    rxcf_pause_timer #(
        .QUANTA_CYC(RXCF_QUANTA_CYC)
    ) u_pause (
        .pclk(pclk),
        .presetn(presetn),
        .load(s.pause_load),
        .quanta(s.ptime),
        .clear(~(s.ctrl[RXCF_B_PAUSE] & full_duplex)),
        .hold(tx_hold)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_RSVD_ZERO: assert property (
        (s.ctrl & ~RXCF_CTRL_MASK) == 16'h0000)
        else $error("reserved control bit set");
    AST_NO_START: assert property (
        (s.st == RXCF_IDLE) && rx_valid && !s.ctrl[RXCF_B_EN]
        |=> s.st == RXCF_IDLE)
        else $error("frame started while disabled");
    AST_FINISH_FRAME: assert property (
        (s.st == RXCF_FRAME) && !(rx_valid && rx_last) |=>
        s.st == RXCF_FRAME)
        else $error("frame cut short");
    AST_BAD_CRC_DROP: assert property (
        push_v && push_last && s.crc_err && !s.ctrl[RXCF_B_KEEP]
        |-> push_disc)
        else $error("crc error frame not discarded");
    AST_BAD_CRC_KEEP: assert property (
        push_v && push_last && s.ctrl[RXCF_B_KEEP] && !s.overrun
        && (s.idx >= RXCF_MIN_LEN) |-> !push_disc)
        else $error("kept crc error frame discarded");
    AST_BCAST: assert property (
        (s.st == RXCF_FRAME) && rx_valid && (s.fill == RXCF_HOLD)
        && s.bc && s.ctrl[RXCF_B_BC] |-> push_v)
        else $error("broadcast not accepted");
    AST_MCAST: assert property (
        (s.st == RXCF_FRAME) && rx_valid && (s.fill == RXCF_HOLD)
        && s.mc && s.ctrl[RXCF_B_MC] |-> push_v)
        else $error("multicast not accepted");
    AST_UCAST: assert property (
        (s.st == RXCF_FRAME) && rx_valid && (s.fill == RXCF_HOLD)
        && !s.mc && s.match && s.ctrl[RXCF_B_UC] |-> push_v)
        else $error("station frame not accepted");
    AST_PROMISC: assert property (
        (s.st == RXCF_FRAME) && rx_valid && (s.fill == RXCF_HOLD)
        && s.ctrl[RXCF_B_PROM] |-> push_v)
        else $error("frame refused in promiscuous mode");
    AST_HASH: assert property (
        (s.st == RXCF_FRAME) && rx_valid && (s.fill == RXCF_HOLD)
        && s.mc && s.ctrl[RXCF_B_HASH] && hash_table[s.crc[5:0]]
        |-> push_v)
        else $error("hash hit not accepted");
    AST_STRIP_LEN: assert property (
        push_v && fifo_ready && push_last && s.ctrl[RXCF_B_STRIP]
        |-> $past(s.st) == RXCF_DRAIN && s.cnt == RXCF_LAST_STRIP)
        else $error("crc not stripped");
    AST_PAUSE_HOLD: assert property (
        s.pause_load && (s.ptime != 16'h0000) && s.ctrl[RXCF_B_PAUSE]
        && full_duplex |=> tx_hold)
        else $error("pause not honoured");
    AST_PAUSE_OFF: assert property (
        !s.ctrl[RXCF_B_PAUSE] ##1 !s.ctrl[RXCF_B_PAUSE] |-> !tx_hold)
        else $error("pause honoured while disabled");

    COV_BCAST_FRAME: cover property (
        push_v && fifo_ready && push_last && s.bc && !push_disc);
    COV_STRIPPED: cover property (
        push_v && push_last && s.ctrl[RXCF_B_STRIP]);
    COV_PAUSE: cover property (s.pause_load ##1 tx_hold);
    COV_DISCARD: cover property (push_v && push_disc);

endmodule

// *** testbench/rxcf_net_model.sv ***
// Purpose: network side byte source feeding the receive filter
// Assumes: one byte per rx_valid pulse, nine cycles between bytes
// Notes: data line shows the inverse of the last byte between bytes
`timescale 1ns/1ns
module rxcf_net_model (
    input wire logic pclk,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    output logic rx_crc_err
);
    initial
    begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
        rx_crc_err = 1'b0;
    end

    // ----------------------------------------
    // frame sender
    // ----------------------------------------
    task automatic send(input logic [47:0] da, input int len,
                        input logic [31:0] tyop, input logic [15:0] tm,
                        input logic bad);
        logic [7:0] b;
        for (int k = 0; k < len; k++)
        begin
            b = 8'(k);
            if (k < 6)
                b = da[47-8*k -: 8];
            else if (k >= 12 && k < 16)
                b = tyop[31-8*(k-12) -: 8];
            else if (k == 16 || k == 17)
                b = tm[15-8*(k-16) -: 8];
            @(posedge pclk);
            rx_valid <= 1'b1;
            rx_data <= b;
            rx_last <= (k == len - 1);
            rx_crc_err <= bad && (k == len - 1);
            @(posedge pclk);
            rx_valid <= 1'b0;
            rx_last <= 1'b0;
            rx_crc_err <= 1'b0;
            rx_data <= ~b;
            repeat (7) @(posedge pclk);
        end
    endtask
endmodule

// *** testbench/rxcf_top_tb.sv ***
// Purpose: self-checking bench of the receive control filter
// Assumes: queue side normally always ready
// Notes: frames carry their index as payload bytes
`timescale 1ns/1ns
module rxcf_top_tb;
    import rxcf_pkg::*;
    localparam logic [47:0] ST = 48'h021122334455;
    localparam logic [47:0] BC = 48'hffffffffffff;
    localparam logic [47:0] MC = 48'h01005e000001;
    localparam logic [47:0] OT = 48'h021122334466;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_last;
    logic rx_crc_err;
    logic full_duplex = 1'b1;
    logic [63:0] hash_table = 64'h0;
    logic q_valid;
    logic [7:0] q_data;
    logic q_last;
    logic q_discard;
    logic q_ready = 1'b1;
    logic tx_hold;
    logic [7:0] got[$];
    logic last_disc;
    int nfr = 0;
    int hold_cyc = 0;
    int cyc = 0;
    int fails = 0;
    int samples_checked = 0;

    always #2 pclk = ~pclk;

    rxcf_net_model net (.pclk(pclk), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_last(rx_last), .rx_crc_err(rx_crc_err));

    rxcf_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_last(rx_last), .rx_crc_err(rx_crc_err),
        .full_duplex(full_duplex), .station_addr(ST),
        .hash_table(hash_table), .q_valid(q_valid), .q_data(q_data),
        .q_last(q_last), .q_discard(q_discard), .q_ready(q_ready),
        .tx_hold(tx_hold));

    // ----------------------------------------
    // monitors and timeout
    // ----------------------------------------
    always @(posedge pclk)
    begin
        cyc++;
        if (tx_hold === 1'b1)
            hold_cyc++;
        if (q_valid === 1'b1 && q_ready === 1'b1)
        begin
            got.push_back(q_data);
            if (q_last === 1'b1)
            begin
                nfr++;
                last_disc = q_discard;
            end
        end
        if (cyc == 40000)
        begin
            fails++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_frame(input int n0, input int lim);
        for (int t = 0; t < lim && nfr == n0; t++)
            @(posedge pclk);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic regs();
        logic [31:0] r;
        logic e;
        apb(1'b0, RXCF_CTRL_OFS, 32'h0, r, e);
        chk("ctrl_reset", {16'h0000, RXCF_CTRL_RST}, r);
        apb(1'b0, RXCF_STATUS_OFS, 32'h0, r, e);
        chk("status_idle", 32'h0, r);
        apb(1'b1, RXCF_CTRL_OFS, 32'hffffffff, r, e);
        apb(1'b0, RXCF_CTRL_OFS, 32'h0, r, e);
        chk("ctrl_mask", {16'h0000, RXCF_CTRL_MASK}, r);
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk("unmapped_err", 32'h1, {31'h0, e});
        chk("unmapped_data", 32'h0, r);
    endtask

    task automatic frame(input logic [15:0] c, input logic [47:0] da,
                         input logic bad, input int n, input logic disc);
        int n0;
        logic [31:0] r;
        logic e;
        apb(1'b1, RXCF_CTRL_OFS, {16'h0000, c}, r, e);
        got.delete();
        n0 = nfr;
        net.send(da, 24, 32'h0, 16'h0, bad);
        wait_frame(n0, 60);
        chk("bytes", n, got.size());
        if (n > 0)
        begin
            chk("discard", {31'h0, disc}, {31'h0, last_disc});
            chk("first", {24'h0, da[47:40]}, {24'h0, got[0]});
            chk("final", n - 1, {24'h0, got[n-1]});
        end
    endtask

    task automatic stop_mid();
        int n0;
        logic [31:0] r;
        logic e;
        apb(1'b1, RXCF_CTRL_OFS, 32'h00000011, r, e);
        got.delete();
        n0 = nfr;
        fork
            net.send(OT, 24, 32'h0, 16'h0, 1'b0);
            begin
                repeat (60) @(posedge pclk);
                apb(1'b0, RXCF_STATUS_OFS, 32'h0, r, e);
                chk("status_busy", 32'h1, r);
                apb(1'b1, RXCF_CTRL_OFS, 32'h00000010, r, e);
            end
        join
        wait_frame(n0, 60);
        chk("bytes_after_stop", 24, got.size());
    endtask

    task automatic overrun();
        int n0;
        logic [31:0] r;
        logic e;
        apb(1'b1, RXCF_CTRL_OFS, 32'h00000011, r, e);
        q_ready <= 1'b0;
        n0 = nfr;
        net.send(OT, 60, 32'h0, 16'h0, 1'b0);
        chk("stall_valid", 32'h1, {31'h0, q_valid});
        q_ready <= 1'b1;
        wait_frame(n0, 200);
        chk("overrun_discard", 32'h1, {31'h0, last_disc});
    endtask

    task automatic pause_case(input logic [15:0] c, input logic fd,
                              input int n);
        logic [31:0] r;
        logic e;
        apb(1'b1, RXCF_CTRL_OFS, {16'h0000, c}, r, e);
        full_duplex <= fd;
        @(posedge pclk);
        hold_cyc = 0;
        net.send(RXCF_PAUSE_DA, 24, RXCF_PAUSE_TYPE_OPC, 16'h0002, 1'b0);
        apb(1'b0, RXCF_STATUS_OFS, 32'h0, r, e);
        chk("status_hold", (n > 0) ? 32'h2 : 32'h0, r);
        for (int t = 0; t < 3000 && tx_hold !== 1'b0; t++)
            @(posedge pclk);
        chk("hold_cycles", n, hold_cyc);
    endtask

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        regs();
        frame(16'h00f0, BC, 1'b0, 0, 1'b0);
        frame(16'h0081, BC, 1'b0, 24, 1'b0);
        frame(16'h0021, BC, 1'b0, 0, 1'b0);
        frame(16'h0041, BC, 1'b0, 24, 1'b0);
        frame(16'h0041, MC, 1'b0, 24, 1'b0);
        frame(16'h0021, ST, 1'b0, 24, 1'b0);
        frame(16'h0021, OT, 1'b0, 0, 1'b0);
        frame(16'h0011, OT, 1'b0, 24, 1'b0);
        frame(16'h0019, OT, 1'b0, 20, 1'b0);
        frame(16'h0011, OT, 1'b1, 24, 1'b1);
        frame(16'h0211, OT, 1'b1, 24, 1'b0);
        hash_table <= 64'hffffffffffffffff;
        frame(16'h0005, MC, 1'b0, 24, 1'b0);
        hash_table <= 64'h0;
        frame(16'h0005, MC, 1'b0, 0, 1'b0);
        stop_mid();
        frame(16'h0010, OT, 1'b0, 0, 1'b0);
        overrun();
        pause_case(16'h0401, 1'b1, 2 * RXCF_QUANTA_CYC);
        // half duplex with pause disabled keeps pause honour off
        pause_case(16'h0001, 1'b0, 0);
        pause_case(16'h0001, 1'b1, 0);
        conclude();
    end
endmodule
